// ===== dac_margin_map.svh
// Address map, field positions and reset values of the margin register bank.
// Assumes a serial front end that hands over byte addresses or PMBus page and command codes.
`ifndef DAC_MARGIN_MAP_SVH
`define DAC_MARGIN_MAP_SVH

// Serial byte addresses
`define ADDR_NULL          8'h00
`define ADDR_HIGH_CH0      8'h01
`define ADDR_LOW_CH0       8'h02
`define ADDR_HIGH_CH1      8'h07
`define ADDR_LOW_CH1       8'h08
`define ADDR_HIGH_CH2      8'h0d
`define ADDR_LOW_CH2       8'h0e
`define ADDR_HIGH_CH3      8'h13
`define ADDR_LOW_CH3       8'h14

// PMBus pages and command codes
`define PMBUS_PAGE_LAST    8'h03
`define PMBUS_PAGE_COMMON  8'hff
`define PMBUS_CMD_HIGH     8'h25
`define PMBUS_CMD_LOW      8'h26
`define PMBUS_CMD_NULL     8'hd0

// Field layout and values
`define CODE_MSB           15
`define CODE_LSB           4
`define NIBBLE_ZERO        4'h0
`define NULL_VALUE         16'h0000
`define CODE_RESET         12'h000
`define CODE_MASK_12       12'hfff
`define CODE_MASK_10       12'hffc

`endif

// ===== dac_margin_pkg.sv
// Types shared by the margin register bank and its code register.
// Assumes nothing beyond the constants header.
package dac_margin_pkg;

    // One register access from the serial front end
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        pmbus;
        logic [7:0]  addr;
        logic [7:0]  page;
        logic [15:0] wdata;
    } access_t;

    // Answer to an access, one cycle later
    typedef struct packed {
        logic        valid;
        logic        hit;
        logic [15:0] rdata;
    } response_t;

    // Codes handed to the converter channels
    typedef struct packed {
        logic [3:0][11:0] high;
        logic [3:0][11:0] low;
    } margin_codes_t;

    // Decode result
    typedef struct packed {
        logic       hit;
        logic       null_hit;
        logic [2:0] index;
    } decode_t;

    typedef struct packed {
        logic [11:0] code;
    } code_state_t;

    typedef struct packed {
        response_t rsp;
    } bank_state_t;

endpackage

// ===== dac_margin_register_map_test.sv
// Self-checking bench for the margin register bank, 12-bit and 10-bit builds.
// Assumes the host model drives the access port and responses come one cycle later.
`timescale 1ns/1ps
module dac_margin_register_map_test;
    logic                          clk_sys = 1'b0;
    logic                          reset   = 1'b1;
    dac_margin_pkg::access_t       access;
    dac_margin_pkg::response_t     response;
    dac_margin_pkg::response_t     response10;
    dac_margin_pkg::margin_codes_t codes;
    dac_margin_pkg::margin_codes_t codes10;
    int                            n_fail    = 0;
    int                            cmp_count = 0;
    logic [16:0]                   expq[$];
    logic [16:0]                   e;
    logic [11:0]                   exp_hi[4];
    logic [11:0]                   exp_lo[4];
    localparam logic [7:0]         hi_addr[4] = '{8'h01, 8'h07, 8'h0d, 8'h13};
    localparam logic [7:0]         lo_addr[4] = '{8'h02, 8'h08, 8'h0e, 8'h14};

    margin_host host (.clk_sys(clk_sys), .access(access));
    dac_margin_regs #(.ten_bit_variant(1'b0)) dut (.clk_sys(clk_sys), .reset(reset), .access(access),
        .response(response), .margin_codes(codes));
    dac_margin_regs #(.ten_bit_variant(1'b1)) dut10 (.clk_sys(clk_sys), .reset(reset), .access(access),
        .response(response10), .margin_codes(codes10));

    // Clock, 10 ns period
    always #5 clk_sys = ~clk_sys;

    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Model the access, note the expected answer, then launch it
    task acc(input logic wr, input logic pm, input logic [7:0] pg, input logic [7:0] a, input logic [15:0] wd);
        logic        hit;
        logic [15:0] rd;
        hit = pm ? (pg == 8'hff && a == 8'hd0) : (a == 8'h00);
        rd  = 16'h0000;
        for (int c = 0; c < 4; c++) begin
            if (pm ? (pg == c[7:0] && a == 8'h25) : (a == hi_addr[c])) begin
                hit = 1'b1;
                rd  = {exp_hi[c], 4'h0};
                if (wr) exp_hi[c] = wd[15:4];
            end
            if (pm ? (pg == c[7:0] && a == 8'h26) : (a == lo_addr[c])) begin
                hit = 1'b1;
                rd  = {exp_lo[c], 4'h0};
                if (wr) exp_lo[c] = wd[15:4];
            end
        end
        if (wr) rd = 16'h0000;
        expq.push_back({hit, rd});
        host.set_page(pg);
        host.send(wr, pm, a, wd);
    endtask

    // Every register by both routes, plus null, unmapped and bad page
    task read_all();
        acc(1'b0, 1'b0, 8'h00, 8'h00, 16'h0000);
        acc(1'b0, 1'b1, 8'hff, 8'hd0, 16'h0000);
        acc(1'b0, 1'b0, 8'h00, 8'h03, 16'h0000);
        acc(1'b0, 1'b1, 8'h04, 8'h25, 16'h0000);
        for (int c = 0; c < 4; c++) begin
            acc(1'b0, 1'b0, 8'h00, hi_addr[c], 16'h0000);
            acc(1'b0, 1'b0, 8'h00, lo_addr[c], 16'h0000);
            acc(1'b0, 1'b1, c[7:0], 8'h25, 16'h0000);
            acc(1'b0, 1'b1, c[7:0], 8'h26, 16'h0000);
        end
        host.idle();
        repeat (2) @(posedge clk_sys);
        for (int c = 0; c < 4; c++) begin
            check("margin_codes.high", {4'h0, codes.high[c]}, {4'h0, exp_hi[c]});
            check("margin_codes.low", {4'h0, codes.low[c]}, {4'h0, exp_lo[c]});
            check("ten bit high", {4'h0, codes10.high[c]}, {4'h0, exp_hi[c] & 12'hffc});
            check("ten bit low", {4'h0, codes10.low[c]}, {4'h0, exp_lo[c] & 12'hffc});
        end
        check("responses left over", 16'(expq.size()), 16'h0000);
    endtask

    // Compare each answer with the oldest note
    always @(posedge clk_sys) begin
        if (response.valid === 1'b1) begin
            if (expq.size() == 0) begin
                check("spare response", 16'h0001, 16'h0000);
            end else begin
                e = expq.pop_front();
                check("response.hit", {15'h0, response.hit}, {15'h0, e[16]});
                check("response.rdata", response.rdata, e[15:0]);
                // Ten-bit build answers alike, code bits 1 and 0 read as zero
                check("ten bit response.valid", {15'h0, response10.valid}, 16'h0001);
                check("ten bit response.hit", {15'h0, response10.hit}, {15'h0, e[16]});
                check("ten bit response.rdata", response10.rdata, e[15:0] & 16'hffcf);
            end
        end
    end

    // Stimulus
    initial begin
        for (int c = 0; c < 4; c++) begin
            exp_hi[c] = 12'h000;
            exp_lo[c] = 12'h000;
        end
        void'($urandom(61854));
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        read_all();
        $display("test reset values done");
        for (int r = 0; r < 3; r++) begin
            acc(1'b1, 1'b0, 8'h00, 8'h00, 16'($urandom));
            acc(1'b1, 1'b0, 8'h00, 8'h03, 16'($urandom));
            for (int c = 0; c < 4; c++) begin
                acc(1'b1, 1'b0, 8'h00, hi_addr[c], 16'($urandom));
                acc(1'b1, 1'b0, 8'h00, lo_addr[c], 16'($urandom));
            end
            read_all();
        end
        $display("test byte address writes done");
        for (int c = 0; c < 5; c++) begin
            acc(1'b1, 1'b1, c[7:0], 8'h25, 16'($urandom));
            acc(1'b1, 1'b1, c[7:0], 8'h26, 16'($urandom));
        end
        acc(1'b1, 1'b1, 8'hff, 8'hd0, 16'hffff);
        read_all();
        $display("test pmbus pages done");
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            exp_hi[c] = 12'h000;
            exp_lo[c] = 12'h000;
        end
        read_all();
        $display("test second reset done");
        give_verdict();
    end

    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        give_verdict();
    end
endmodule // dac_margin_register_map_test

// ===== dac_margin_regs.sv
// Margin register bank: null register and per-channel margin-high and margin-low codes.
// Assumes the serial engines and the page register sit outside and present one access per valid cycle.
//
// Behaviour
// (RL1) Byte address 00h is a read-only null register that always reads zero and has no side effect.
// (RL2) Margin-high codes of channels 0 to 3 sit at 01h, 07h, 0Dh and 13h and reset to zero.
// (RL3) Margin-low codes of channels 0 to 3 sit at 02h, 08h, 0Eh and 14h and reset to zero.
// (RL4) Over PMBus, page 00h to 03h picks the channel and command 25h reaches its margin-high code.
// (RL5) Over PMBus, page 00h to 03h picks the channel and command 26h reaches its margin-low code.
// (RL6) Each code is unsigned straight binary in word bits 15 to 4, with bits 3 to 0 ignored.
// (RL7) The 12-bit variant keeps all twelve code bits; the 10-bit variant drops the lowest two.
// (RL8) The margin-high code is read-write and resets to 000h.
// (RL9) The margin-low code is read-write, resets to 000h and has the same format as margin-high.
// (RL10) Writes to the low nibble have no effect and reads of it return zero.
`timescale 1ns/1ps
`include "dac_margin_map.svh"

module dac_margin_regs #(
    parameter bit ten_bit_variant = 1'b0
) (
    input  wire logic                          clk_sys,
    input  wire logic                          reset,
    input  wire dac_margin_pkg::access_t       access,
    output dac_margin_pkg::response_t          response,
    output dac_margin_pkg::margin_codes_t      margin_codes
);

    localparam logic [11:0] code_mask = ten_bit_variant ? `CODE_MASK_10 : `CODE_MASK_12;

    dac_margin_pkg::bank_state_t state;
    dac_margin_pkg::bank_state_t next_state;
    dac_margin_pkg::decode_t     dec;
    logic [7:0][11:0]            code_q;
    logic [7:0]                  write_en;
    logic [11:0]                 write_code;

    // Map an access to a code register index (channel * 2 + low)
    function automatic dac_margin_pkg::decode_t decode(input dac_margin_pkg::access_t a);
        dac_margin_pkg::decode_t d;
        d = '0;
        if (a.pmbus) begin
            if (a.page <= `PMBUS_PAGE_LAST && a.addr == `PMBUS_CMD_HIGH) begin
                d.hit   = 1'b1; // RL4
                d.index = {a.page[1:0], 1'b0};
            end else if (a.page <= `PMBUS_PAGE_LAST && a.addr == `PMBUS_CMD_LOW) begin
                d.hit   = 1'b1; // RL5
                d.index = {a.page[1:0], 1'b1};
            end else if (a.page == `PMBUS_PAGE_COMMON && a.addr == `PMBUS_CMD_NULL) begin
                d.null_hit = 1'b1;
            end
        end else begin
            // RL2 RL3
            unique case (a.addr)
                `ADDR_NULL: d.null_hit = 1'b1; // RL1
                `ADDR_HIGH_CH0: begin d.hit = 1'b1; d.index = 3'h0; end
                `ADDR_LOW_CH0:  begin d.hit = 1'b1; d.index = 3'h1; end
                `ADDR_HIGH_CH1: begin d.hit = 1'b1; d.index = 3'h2; end
                `ADDR_LOW_CH1:  begin d.hit = 1'b1; d.index = 3'h3; end
                `ADDR_HIGH_CH2: begin d.hit = 1'b1; d.index = 3'h4; end
                `ADDR_LOW_CH2:  begin d.hit = 1'b1; d.index = 3'h5; end
                `ADDR_HIGH_CH3: begin d.hit = 1'b1; d.index = 3'h6; end
                `ADDR_LOW_CH3:  begin d.hit = 1'b1; d.index = 3'h7; end
                default: d = '0;
            endcase
        end
        return d;
    endfunction

    // Decode and write strobes
    always_comb begin
        dec        = decode(access);
        write_en   = '0;
        write_code = access.wdata[`CODE_MSB:`CODE_LSB]; // RL6 RL10
        if (access.valid && access.write && dec.hit) begin
            write_en[dec.index] = 1'b1;
        end
    end

    // Code storage: even index margin-high, odd index margin-low
    for (genvar g = 0; g < 8; g++) begin : g_code
        margin_code_reg #(
            .code_mask (code_mask)
        ) u_code (
            .clk_sys    (clk_sys),
            .reset      (reset),
            .write_en   (write_en[g]),
            .write_code (write_code),
            .code       (code_q[g])
        );
    end

    // Spread codes to channels
    always_comb begin
        margin_codes = '0;
        for (int c = 0; c < 4; c++) begin
            margin_codes.high[c] = code_q[2 * c];     // RL8
            margin_codes.low[c]  = code_q[2 * c + 1]; // RL9
        end
    end

    // Answer: read data with a zero nibble, null reads zero
    always_comb begin
        next_state           = state;
        next_state.rsp.valid = access.valid;
        next_state.rsp.hit   = access.valid && (dec.hit || dec.null_hit);
        next_state.rsp.rdata = `NULL_VALUE; // RL1
        if (access.valid && !access.write && dec.hit) begin
            next_state.rsp.rdata = {code_q[dec.index], `NIBBLE_ZERO}; // RL10
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign response = state.rsp;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_null_reads_zero: assert property ( // RL1
        access.valid && !access.write && !access.pmbus && access.addr == `ADDR_NULL
        |=> response.valid && response.hit && response.rdata == `NULL_VALUE)
        else $error("null register did not read zero");

    a_null_no_effect: assert property ( // RL1
        access.valid && access.write && !access.pmbus && access.addr == `ADDR_NULL
        |=> $stable(margin_codes))
        else $error("write to null register changed a code");

    a_high_ch0_write: assert property ( // RL2
        access.valid && access.write && !access.pmbus && access.addr == `ADDR_HIGH_CH0
        |=> margin_codes.high[0] == ($past(access.wdata[`CODE_MSB:`CODE_LSB]) & code_mask))
        else $error("margin-high channel 0 not written");

    a_low_ch3_write: assert property ( // RL3
        access.valid && access.write && !access.pmbus && access.addr == `ADDR_LOW_CH3
        |=> margin_codes.low[3] == ($past(access.wdata[`CODE_MSB:`CODE_LSB]) & code_mask))
        else $error("margin-low channel 3 not written");

    a_pmbus_high_map: assert property ( // RL4
        access.valid && access.write && access.pmbus && access.page == 8'h02
        && access.addr == `PMBUS_CMD_HIGH
        |=> margin_codes.high[2] == ($past(access.wdata[`CODE_MSB:`CODE_LSB]) & code_mask))
        else $error("PMBus margin-high map wrong");

    a_pmbus_low_map: assert property ( // RL5
        access.valid && access.write && access.pmbus && access.page == 8'h01
        && access.addr == `PMBUS_CMD_LOW
        |=> margin_codes.low[1] == ($past(access.wdata[`CODE_MSB:`CODE_LSB]) & code_mask))
        else $error("PMBus margin-low map wrong");

    a_read_aligned: assert property ( // RL6
        access.valid && !access.write && !access.pmbus && access.addr == `ADDR_HIGH_CH2
        |=> response.rdata == {$past(margin_codes.high[2]), `NIBBLE_ZERO})
        else $error("read data not MSB aligned");

    a_ten_bit_lsbs: assert property ( // RL7
        ten_bit_variant |-> (margin_codes.high[1][1:0] == 2'h0 && margin_codes.low[1][1:0] == 2'h0))
        else $error("ten-bit variant kept low code bits");

    a_reset_codes_zero: assert property ( // RL8 RL9
        $past(reset) |-> margin_codes == '0)
        else $error("codes not zero after reset");

    a_nibble_reads_zero: assert property ( // RL10
        response.valid |-> response.rdata[3:0] == `NIBBLE_ZERO)
        else $error("low nibble read not zero");

    c_null_read: cover property (
        access.valid && !access.write && !access.pmbus && access.addr == `ADDR_NULL);
    c_pmbus_write: cover property (
        access.valid && access.write && access.pmbus && access.addr == `PMBUS_CMD_LOW);
    c_write_then_read: cover property (
        write_en[5] ##1 access.valid && !access.write && access.addr == `ADDR_LOW_CH2);

endmodule // dac_margin_regs

// ===== margin_code_reg.sv
// One 12-bit margin code register with a resolution mask.
// Assumes a single-cycle write strobe on the clk_sys domain.
`timescale 1ns/1ps
`include "dac_margin_map.svh"

module margin_code_reg #(
    parameter logic [11:0] code_mask = `CODE_MASK_12
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        write_en,
    input  wire logic [11:0] write_code,
    output logic      [11:0] code
);

    dac_margin_pkg::code_state_t state;
    dac_margin_pkg::code_state_t next_state;

    // Store masked code; dropped bits stay zero
    always_comb begin
        next_state = state;
        if (write_en) begin
            next_state.code = write_code & code_mask; // RL7
        end
    end

    // Register with reset to zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state.code <= `CODE_RESET; // RL8
        end else begin
            state <= next_state;
        end
    end

    assign code = state.code;

endmodule // margin_code_reg

// ===== margin_host.sv
// Host model that presents register accesses to the margin bank.
// Assumes one access per clock and a PMBus page register on the host side.
`timescale 1ns/1ps
module margin_host (
    input  wire logic              clk_sys,
    output dac_margin_pkg::access_t access
);
    logic [7:0] page;

    // Port idle until the first request
    initial begin
        access = '0;
        page   = 8'h00;
    end

    // Page select used by later PMBus commands
    task set_page(input logic [7:0] p);
        page = p;
    endtask

    // One access launched after an edge, held until the edge that takes it
    task send(input logic wr, input logic pm, input logic [7:0] a, input logic [15:0] wd);
        @(posedge clk_sys);
        access <= '{valid: 1'b1, write: wr, pmbus: pm, addr: a, page: page, wdata: wd};
    endtask

    // Released port shows no stale address or data
    task idle();
        @(posedge clk_sys);
        access <= '{valid: 1'b0, write: 1'b0, pmbus: 1'b0, addr: ~access.addr, page: ~page, wdata: ~access.wdata};
    endtask
endmodule // margin_host
